// ===== rtl/mrid_pkg.sv
// shared constants and types for the move/rotate instruction decoder
package mrid_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int unsigned MRID_IW  = 12;   // instruction word width
  localparam int unsigned MRID_DW  = 8;    // data path width
  localparam int unsigned MRID_FAW = 5;    // file register address width
  localparam int unsigned MRID_PCW = 10;   // program counter width
  localparam int unsigned MRID_AW  = 6;    // software port address width

  // ---------------------------------------------------------------------------
  // opcode masks and match values
  // ---------------------------------------------------------------------------
  localparam logic [11:0] MRID_MOVE_FILE_MASK = 12'hfc0;
  localparam logic [11:0] MRID_MOVE_FILE_VAL  = 12'h200;
  localparam logic [11:0] MRID_STORE_ACC_MASK = 12'hfe0;
  localparam logic [11:0] MRID_STORE_ACC_VAL  = 12'h020;
  localparam logic [11:0] MRID_LOAD_LIT_MASK  = 12'hf00;
  localparam logic [11:0] MRID_LOAD_LIT_VAL   = 12'hc00;
  localparam logic [11:0] MRID_ROT_LEFT_MASK  = 12'hfc0;
  localparam logic [11:0] MRID_ROT_LEFT_VAL   = 12'h340;
  localparam logic [11:0] MRID_LOAD_CFG_WORD  = 12'h002;
  localparam logic [11:0] MRID_NOP_WORD       = 12'h000;

  // ---------------------------------------------------------------------------
  // field positions inside the instruction word
  // ---------------------------------------------------------------------------
  localparam int unsigned MRID_DIR_BIT   = 5;  // direction bit d
  localparam int unsigned MRID_FADDR_LSB = 0;  // file address field low bit
  localparam int unsigned MRID_LIT_LSB   = 0;  // literal field low bit

  // ---------------------------------------------------------------------------
  // software port map (file registers sit at 0x00..0x1f)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] MRID_ADDR_ACC    = 6'h20;
  localparam logic [5:0] MRID_ADDR_STATUS = 6'h21;
  localparam logic [5:0] MRID_ADDR_CFG    = 6'h22;
  localparam logic [5:0] MRID_ADDR_PC_LO  = 6'h23;
  localparam logic [5:0] MRID_ADDR_PC_HI  = 6'h24;
  localparam int unsigned MRID_STAT_CARRY = 0;  // carry bit in status
  localparam int unsigned MRID_STAT_ZERO  = 2;  // zero bit in status

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MRID_ACC_RST = 8'h00;
  localparam logic [7:0] MRID_CFG_RST = 8'hff;
  localparam logic [9:0] MRID_PC_RST  = 10'h000;
  localparam logic [7:0] MRID_MEM_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // decoded operation
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MRID_OP_NOP       = 3'h0,
    MRID_OP_MOVE_FILE = 3'h1,
    MRID_OP_STORE_ACC = 3'h2,
    MRID_OP_LOAD_LIT  = 3'h3,
    MRID_OP_LOAD_CFG  = 3'h4,
    MRID_OP_ROT_LEFT  = 3'h5,
    MRID_OP_OTHER     = 3'h6
  } mrid_op_t;

endpackage

// ===== rtl/mrid_decode.sv
// instruction word to operation and operand fields
`timescale 1ns/100ps

module mrid_decode
  import mrid_pkg::*;
(
  input  wire logic [11:0] instr_i,  // instruction word
  output mrid_op_t         op_o,     // decoded operation
  output logic             dir_o,    // 1: result to file register
  output logic [4:0]       faddr_o,  // file register address
  output logic [7:0]       lit_o     // immediate literal
);

  // ---------------------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------------------
  assign dir_o   = instr_i[MRID_DIR_BIT];
  assign faddr_o = instr_i[MRID_FADDR_LSB +: 5];
  assign lit_o   = instr_i[MRID_LIT_LSB +: 8];

  // ---------------------------------------------------------------------------
  // opcode match; exact words are tested first, though none of the masks would match them
  // ---------------------------------------------------------------------------
  always_comb begin
    if (instr_i == MRID_NOP_WORD) begin
      op_o = MRID_OP_NOP;
    end else if (instr_i == MRID_LOAD_CFG_WORD) begin
      op_o = MRID_OP_LOAD_CFG;
    end else if ((instr_i & MRID_MOVE_FILE_MASK) == MRID_MOVE_FILE_VAL) begin
      op_o = MRID_OP_MOVE_FILE;
    end else if ((instr_i & MRID_STORE_ACC_MASK) == MRID_STORE_ACC_VAL) begin
      op_o = MRID_OP_STORE_ACC;
    end else if ((instr_i & MRID_LOAD_LIT_MASK) == MRID_LOAD_LIT_VAL) begin
      op_o = MRID_OP_LOAD_LIT;
    end else if ((instr_i & MRID_ROT_LEFT_MASK) == MRID_ROT_LEFT_VAL) begin
      op_o = MRID_OP_ROT_LEFT;
    end else begin
      op_o = MRID_OP_OTHER;       // handled by other blocks of the core
    end
  end

endmodule

// ===== rtl/mrid_core.sv
// move/rotate instruction executor with file registers, accumulator and flags
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps

// Behaviour
// - decode move-file, read addressed file register
// - move-file direction: accumulator or same register
// - move-file sets zero flag from value
// - store-accumulator writes file, flags untouched
// - load-literal puts immediate into accumulator
// - load-configuration copies accumulator to config
// - rotate-left through carry, carry only flag
// - rotate-left direction: accumulator or register
module mrid_core
  import mrid_pkg::*;
(
  input  wire logic        MCLK_I,         // core clock, 25 MHz
  input  wire logic        NRST_I,         // synchronous reset, active low
  input  wire logic [11:0] INSTR_I,        // instruction word
  input  wire logic        INSTR_VALID_I,  // one instruction cycle this clock
  input  wire logic [5:0]  ADDR_I,         // software port address
  input  wire logic [7:0]  WDATA_I,        // software write data
  input  wire logic        WR_I,           // software write strobe
  input  wire logic        RD_I,           // software read strobe
  output logic      [7:0]  RDATA_O,        // read data, cycle after RD_I
  output logic      [7:0]  ACC_O,          // accumulator
  output logic             CARRY_O,        // carry flag
  output logic             ZERO_O,         // zero flag
  output logic      [7:0]  CONFIG_O,       // prescaler/timer configuration
  output logic      [9:0]  PC_O,           // program counter
  output logic             UNSUPP_O        // pulse: word not handled here
);

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  logic [7:0] file_mem [32];  // file register space
  logic [7:0] acc_q;          // accumulator
  logic       carry_q;        // carry flag
  logic       zero_q;         // zero flag
  logic [7:0] cfg_q;          // configuration register
  logic [9:0] pc_q;           // program counter
  logic [7:0] rdata_q;        // read data holding flop
  logic       unsupp_q;       // unsupported word pulse

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  mrid_op_t   op;             // decoded operation
  logic       dir;            // direction bit
  logic [4:0] faddr;          // file address
  logic [7:0] lit;            // literal
  logic [7:0] fval;           // addressed file register value
  logic [7:0] rot_val;        // rotate-left result
  logic       exec;           // instruction executes this clock

  mrid_decode u_decode (
    .instr_i (INSTR_I),
    .op_o    (op),
    .dir_o   (dir),
    .faddr_o (faddr),
    .lit_o   (lit)
  );

  assign exec    = INSTR_VALID_I;
  assign fval    = file_mem[faddr];
  assign rot_val = {fval[6:0], carry_q};

  // software decode of the file register map
  logic sw_file;              // write targets a file register
  assign sw_file = WR_I && (ADDR_I[5] == 1'b0);

  // ---------------------------------------------------------------------------
  // file register space
  // ---------------------------------------------------------------------------
  // instruction write comes last so it wins over a software write to the same
  // entry in the same clock; the core owns the datapath in that cycle
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 32; i++) begin
        file_mem[i] <= MRID_MEM_RST;
      end
    end else begin
      if (sw_file) begin
        file_mem[ADDR_I[4:0]] <= WDATA_I;
      end
      if (exec) begin
        case (op)
          MRID_OP_MOVE_FILE: begin
            if (dir) begin
              file_mem[faddr] <= fval;
            end
          end
          MRID_OP_STORE_ACC: begin
            file_mem[faddr] <= acc_q;
          end
          MRID_OP_ROT_LEFT: begin
            if (dir) begin
              file_mem[faddr] <= rot_val;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // accumulator
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      acc_q <= MRID_ACC_RST;
    end else if (exec && (op == MRID_OP_MOVE_FILE) && !dir) begin
      acc_q <= fval;
    end else if (exec && (op == MRID_OP_LOAD_LIT)) begin
      acc_q <= lit;
    end else if (exec && (op == MRID_OP_ROT_LEFT) && !dir) begin
      acc_q <= rot_val;
    end else if (WR_I && (ADDR_I == MRID_ADDR_ACC)) begin
      acc_q <= WDATA_I;                             // software load, lowest priority
    end
  end

  // ---------------------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------------------
  // hardware update beats a software write in the same clock so no event is lost
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      zero_q <= 1'b0;
    end else if (exec && (op == MRID_OP_MOVE_FILE)) begin
      zero_q <= (fval == 8'h00);
    end else if (WR_I && (ADDR_I == MRID_ADDR_STATUS)) begin
      zero_q <= WDATA_I[MRID_STAT_ZERO];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      carry_q <= 1'b0;
    end else if (exec && (op == MRID_OP_ROT_LEFT)) begin
      carry_q <= fval[7];
    end else if (WR_I && (ADDR_I == MRID_ADDR_STATUS)) begin
      carry_q <= WDATA_I[MRID_STAT_CARRY];
    end
  end

  // ---------------------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      cfg_q <= MRID_CFG_RST;
    end else if (exec && (op == MRID_OP_LOAD_CFG)) begin
      cfg_q <= acc_q;
    end else if (WR_I && (ADDR_I == MRID_ADDR_CFG)) begin
      cfg_q <= WDATA_I;
    end
  end

  // ---------------------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------------------
  // every word is one cycle here; branches belong to another block, so the
  // counter simply steps and wraps at the top of the space
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      pc_q <= MRID_PC_RST;
    end else if (exec) begin
      pc_q <= pc_q + 10'h001;
    end else if (WR_I && (ADDR_I == MRID_ADDR_PC_LO)) begin
      pc_q <= {pc_q[9:8], WDATA_I};
    end else if (WR_I && (ADDR_I == MRID_ADDR_PC_HI)) begin
      pc_q <= {WDATA_I[1:0], pc_q[7:0]};
    end
  end

  // ---------------------------------------------------------------------------
  // unsupported word flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      unsupp_q <= 1'b0;
    end else begin
      unsupp_q <= exec && (op == MRID_OP_OTHER);
    end
  end

  // ---------------------------------------------------------------------------
  // software read port
  // ---------------------------------------------------------------------------
  // data stand only in the cycle after the strobe; zero otherwise
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      rdata_q <= 8'h00;
    end else if (RD_I) begin
      if (ADDR_I[5] == 1'b0) begin
        rdata_q <= file_mem[ADDR_I[4:0]];
      end else begin
        case (ADDR_I)
          MRID_ADDR_ACC:    rdata_q <= acc_q;
          MRID_ADDR_STATUS: rdata_q <= {5'h00, zero_q, 1'b0, carry_q};
          MRID_ADDR_CFG:    rdata_q <= cfg_q;
          MRID_ADDR_PC_LO:  rdata_q <= pc_q[7:0];
          MRID_ADDR_PC_HI:  rdata_q <= {6'h00, pc_q[9:8]};
          default:          rdata_q <= 8'h00;  // unmapped reads as zero
        endcase
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign RDATA_O  = rdata_q;
  assign ACC_O    = acc_q;
  assign CARRY_O  = carry_q;
  assign ZERO_O   = zero_q;
  assign CONFIG_O = cfg_q;
  assign PC_O     = pc_q;
  assign UNSUPP_O = unsupp_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  logic idle_sw;              // no software write this clock
  assign idle_sw = !WR_I;

  a_move_to_acc: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_MOVE_FILE) && !dir |=> acc_q == $past(fval))
    else $error("move-file did not load accumulator");

  a_move_zero: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_MOVE_FILE) |=> zero_q == ($past(fval) == 8'h00))
    else $error("move-file zero flag wrong");

  a_store_acc_file: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_STORE_ACC) && idle_sw
    |=> file_mem[$past(faddr)] == $past(acc_q) && $stable(carry_q) && $stable(zero_q))
    else $error("store-accumulator wrong or touched flags");

  a_literal_load: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_LOAD_LIT) && idle_sw
    |=> acc_q == $past(lit) && $stable(carry_q) && $stable(zero_q))
    else $error("load-literal wrong or touched flags");

  a_config_load: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_LOAD_CFG) && idle_sw
    |=> cfg_q == $past(acc_q) && $stable(zero_q) && $stable(carry_q))
    else $error("load-configuration wrong");

  a_rotate_carry: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_ROT_LEFT) && idle_sw
    |=> carry_q == $past(fval[7]) && $stable(zero_q))
    else $error("rotate-left carry wrong");

  a_rotate_dest: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_ROT_LEFT) && !dir
    |=> acc_q == {$past(fval[6:0]), $past(carry_q)})
    else $error("rotate-left accumulator result wrong");

  a_nop_quiet: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_NOP) && idle_sw
    |=> $stable(acc_q) && $stable(cfg_q) && $stable(carry_q) && $stable(zero_q))
    else $error("no-operation changed state");

  a_pc_step: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec ##1 exec |=> pc_q == $past(pc_q, 2) + 10'h002)
    else $error("program counter did not step once per cycle");

  // the write-back flavour of a move is a pure zero test, so nothing else moves
  a_move_keep_file: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_MOVE_FILE) && dir && idle_sw
    |=> file_mem[$past(faddr)] == $past(fval) && $stable(acc_q))
    else $error("move-file write-back changed value or accumulator");

  // rotate into the file must leave the accumulator alone
  a_rotate_file: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_ROT_LEFT) && dir && idle_sw
    |=> file_mem[$past(faddr)] == {$past(fval[6:0]), $past(carry_q)} && $stable(acc_q))
    else $error("rotate-left file result wrong");

  // every executed word, supported or not, steps the counter exactly once
  a_pc_single: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec |=> pc_q == $past(pc_q) + 10'h001)
    else $error("program counter did not step by one");

  // words for other blocks are flagged one cycle later and for one cycle only
  a_unsupp_flag: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    exec && (op == MRID_OP_OTHER) |=> unsupp_q)
    else $error("unsupported word not flagged");

  a_unsupp_quiet: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    !(exec && (op == MRID_OP_OTHER)) |=> !unsupp_q)
    else $error("unsupported flag raised without cause");

  // a stale byte on the read port would look like a second read
  a_read_idle: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    !RD_I |=> rdata_q == 8'h00)
    else $error("read data not zero outside read cycle");

endmodule

// ===== verification/move_rotate_instr_decode_bench.sv
// self-checking bench for the move/rotate instruction executor
`timescale 1ns/100ps

module move_rotate_instr_decode_bench
  import mrid_pkg::*;
  ;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic        clk      = 1'b0;    // 25 MHz core clock
  logic        nrst     = 1'b0;    // synchronous reset, active low
  logic [11:0] instr    = 12'h000; // instruction word
  logic        valid    = 1'b0;    // execute strobe
  logic [5:0]  addr     = 6'h00;   // software address
  logic [7:0]  wdata    = 8'h00;   // software write data
  logic        wr       = 1'b0;    // software write strobe
  logic        rd       = 1'b0;    // software read strobe
  logic [7:0]  rdata;              // read data
  logic [7:0]  acc;                // accumulator
  logic [7:0]  cfg;                // configuration register
  logic        carry;              // carry flag
  logic        zero;               // zero flag
  logic [9:0]  pc;                 // program counter
  logic        unsupp;             // unsupported-word pulse
  int          fail_count = 0;     // mismatches seen
  int          tests_run  = 0;     // comparisons made
  logic [9:0]  exp_pc     = 10'h000; // expected counter, one per executed word

  always #20 clk = ~clk;

  mrid_core DUT (
    .MCLK_I        (clk),
    .NRST_I        (nrst),
    .INSTR_I       (instr),
    .INSTR_VALID_I (valid),
    .ADDR_I        (addr),
    .WDATA_I       (wdata),
    .WR_I          (wr),
    .RD_I          (rd),
    .RDATA_O       (rdata),
    .ACC_O         (acc),
    .CARRY_O       (carry),
    .ZERO_O        (zero),
    .CONFIG_O      (cfg),
    .PC_O          (pc),
    .UNSUPP_O      (unsupp)
  );

  // ---------------------------------------------------------------------------
  // verdict and compare tasks
  // ---------------------------------------------------------------------------
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_pc();
    tests_run++;
    if (pc !== exp_pc) begin
      fail_count++;
      $display("[ERR] program counter expected %h seen %h", exp_pc, pc);
    end
  endtask

  // accumulator, both flags and the counter in one go
  task automatic chk_core(input logic [7:0] a, input logic c, input logic z);
    chk_byte("accumulator", a, acc);
    chk_bit("carry flag", c, carry);
    chk_bit("zero flag", z, zero);
    chk_pc();
  endtask

  // ---------------------------------------------------------------------------
  // drivers: instruction port and software port
  // ---------------------------------------------------------------------------
  // valid is left high so words can follow back to back; idle closes a run
  task automatic exec(input logic [11:0] w);
    @(posedge clk);
    instr <= w;
    valid <= 1'b1;
    exp_pc = exp_pc + 10'h001;
  endtask

  task automatic idle();
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe, so sample there
  task automatic rd_check(input logic [5:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk_byte(name, exp, rdata);
    @(posedge clk);
    #1;
    chk_byte("read data after strobe", 8'h00, rdata);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk_core(8'h00, 1'b0, 1'b0);
    chk_byte("configuration", MRID_CFG_RST, cfg);
    rd_check(6'h1f, 8'h00, "file 1f after reset");
  endtask

  // flags preset to 1 so that any stray update shows
  task automatic t_literal_store();
    wr_reg(MRID_ADDR_STATUS, 8'h05);
    exec(12'hca5);
    exec(12'h03f);
    idle();
    chk_core(8'ha5, 1'b1, 1'b1);
    rd_check(6'h1f, 8'ha5, "file 1f after store");
  endtask

  task automatic t_move();
    exec(12'hc00);
    exec(12'h21f);
    idle();
    chk_core(8'ha5, 1'b1, 1'b0);
    exec(12'h223);
    idle();
    chk_core(8'ha5, 1'b1, 1'b1);
    rd_check(6'h03, 8'h00, "file 03 after test");
    wr_reg(6'h05, 8'h80);
    exec(12'h225);
    idle();
    chk_core(8'ha5, 1'b1, 1'b0);
    rd_check(6'h05, 8'h80, "file 05 after test");
  endtask

  task automatic t_config();
    exec(12'hc3c);
    exec(MRID_LOAD_CFG_WORD);
    idle();
    chk_byte("configuration", 8'h3c, cfg);
    chk_core(8'h3c, 1'b1, 1'b0);
  endtask

  // carry in, carry out and both directions, three words, the last two back to back
  task automatic t_rotate();
    wr_reg(6'h07, 8'he6);
    wr_reg(6'h08, 8'h41);
    wr_reg(MRID_ADDR_STATUS, 8'h04);
    exec(12'h347);
    idle();
    chk_core(8'hcc, 1'b1, 1'b1);
    rd_check(6'h07, 8'he6, "file 07 kept");
    exec(12'h367);
    exec(12'h348);
    idle();
    chk_core(8'h83, 1'b0, 1'b1);
    rd_check(6'h07, 8'hcd, "file 07 rotated");
    rd_check(MRID_ADDR_STATUS, 8'h04, "status");
  endtask

  task automatic t_nop();
    exec(MRID_NOP_WORD);
    idle();
    chk_core(8'h83, 1'b0, 1'b1);
    chk_byte("configuration", 8'h3c, cfg);
    chk_bit("unsupported pulse", 1'b0, unsupp);
  endtask

  // a word for another block only steps the counter and pulses the flag
  task automatic t_unsupp();
    exec(12'h100);
    idle();
    chk_bit("unsupported pulse", 1'b1, unsupp);
    chk_core(8'h83, 1'b0, 1'b1);
    @(posedge clk);
    #1;
    chk_bit("unsupported pulse end", 1'b0, unsupp);
    rd_check(MRID_ADDR_PC_LO, exp_pc[7:0], "counter low byte");
  endtask

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    #1;
    t_reset();
    t_literal_store();
    t_move();
    t_config();
    t_rotate();
    t_nop();
    t_unsupp();
    give_verdict();
  end

  // the whole run needs under a hundred cycles; 5000 leaves wide margin
  initial begin
    #(40 * 5000);
    fail_count++;
    give_verdict();
  end

endmodule
